//--- rtl/timer_pkg.sv
// Register map, field layouts, modes and reset values of the dual-channel capture and PWM timer.
package timer_pkg;

	localparam int ADDR_W = 8;

	// Byte offsets of the word registers on the bus.
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_CLR0    = 8'h04;
	localparam logic [7:0] OFF_CLR1    = 8'h08;
	localparam logic [7:0] OFF_IO0     = 8'h0C;
	localparam logic [7:0] OFF_IO1     = 8'h10;
	localparam logic [7:0] OFF_OUTINIT = 8'h14;
	localparam logic [7:0] OFF_POL     = 8'h18;
	localparam logic [7:0] OFF_STATUS  = 8'h1C;
	localparam logic [7:0] OFF_CNT0    = 8'h20;
	localparam logic [7:0] OFF_CNT1    = 8'h24;
	localparam logic [7:0] OFF_GR_BASE = 8'h30;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Per-pin capture field: edge select in the low two bits, enable above.
	localparam logic [1:0] EDGE_RISE  = 2'h1;
	localparam logic [1:0] EDGE_FALL  = 2'h2;
	localparam logic [1:0] EDGE_BOTH  = 2'h3;
	localparam int         IO_FIELD_W = 4;
	localparam int         CAP_EN_BIT = 2;

	localparam int PINS_PER_CH = 4;
	localparam int NUM_PINS    = 8;
	localparam int TOGGLE_PIN  = 2;
	localparam int PHASE_NORM_PIN [3] = '{1, 4, 5};
	localparam int PHASE_CNTR_PIN [3] = '{3, 6, 7};
	localparam int PHASE_CP_REG   [3] = '{1, 4, 5};

	typedef enum logic [1:0] {MODE_TIMER, MODE_PWM, MODE_RSYNC, MODE_COMPL} mode_t;
	typedef enum logic [1:0] {CLR_NONE, CLR_A, CLR_B, CLR_SYNC} clr_src_t;

	typedef struct packed {
		logic       counter_phase_level_select;
		logic       normal_phase_level_select;
		mode_t      mode;
		logic       sync;
		logic [1:0] start;
	} ctrl_t;

	localparam ctrl_t       CTRL_RST    = '0;
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [15:0] GR_RST      = 16'hFFFF;
	localparam logic [15:0] IO_RST      = 16'h0000;
	localparam logic [15:0] OUTINIT_RST = 16'h0000;
	localparam logic [7:0]  POL_RST     = 8'h00;
	localparam logic [7:0]  TAKEN_OE    = 8'hFE;

endpackage

//--- rtl/dual_channel_capture_pwm_timer.sv
// Two-channel 16-bit capture and PWM timer with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dual_channel_capture_pwm_timer #(
	parameter int CW = 16
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  pin_in,
	output logic [7:0]       pin_out,
	output logic [7:0]       pin_oe
);

	timer_pkg::ctrl_t    ctrl_reg;
	timer_pkg::clr_src_t clr_src_reg [2];
	logic [15:0]         io_ctrl_reg [2];
	logic [15:0]         outinit_reg;
	logic [7:0]          pol_reg;
	logic [CW-1:0]       cnt_reg     [2];
	logic [CW-1:0]       gr_reg      [8];
	logic [7:0]          pin_prev_reg;
	logic [2:0]          phase_reg;
	logic                dir_down_reg;
	logic [7:0]          aw_addr_reg;
	logic                aw_full_reg;
	logic [31:0]         w_data_reg;
	logic [3:0]          w_strb_reg;
	logic                w_full_reg;

	logic [1:0]    tick;
	logic [7:0]    match;
	logic [7:0]    capture;
	logic [1:0]    own_clear;
	logic [1:0]    sync_clear;
	logic          turn_down;
	logic          turn_up;
	logic          dir_eff;
	logic          wr_go;
	logic [7:0]    waddr;
	logic          wr_hit;
	logic [1:0]    wr_cnt;
	logic [7:0]    wr_gr;
	logic [CW-1:0] cnt_wval;
	logic [31:0]   rd_word;
	logic          rd_ok;
	logic [7:0]    pin_out_next;
	logic [7:0]    pin_oe_next;
	logic [2:0]    phase_next;
	logic          dir_down_next;

	// Byte-lane merge of a write into an existing register word.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Zero extension of a counter-width value to a bus word.
	function automatic logic [31:0] pad(input logic [CW-1:0] v);
		return {{(32-CW){1'b0}}, v};
	endfunction

	// The level select picks active-high when set, active-low when clear.
	function automatic logic level(input logic active, input logic sel);
		return sel ? active : ~active;
	endfunction

	assign tick = ctrl_reg.start;

	// Compare and capture per pin; a counter that is stopped never matches, so a match
	// marks the last cycle at the matching value while the count moves on.
	always_comb begin
		logic [CW-1:0] src;
		logic          tk;
		logic          taken;
		logic [3:0]    cfg;
		logic          rise;
		logic          fall;
		logic          hit;
		src   = '0;
		tk    = 1'b0;
		taken = 1'b0;
		cfg   = '0;
		rise  = 1'b0;
		fall  = 1'b0;
		hit   = 1'b0;
		for (int i = 0; i < timer_pkg::NUM_PINS; i++) begin
			if (i >= timer_pkg::PINS_PER_CH && ctrl_reg.mode != timer_pkg::MODE_RSYNC) begin
				src = cnt_reg[1];
				tk  = tick[1];
			end else begin
				src = cnt_reg[0];
				tk  = tick[0];
			end
			match[i] = tk && (src == gr_reg[i]);
			taken = ((ctrl_reg.mode == timer_pkg::MODE_RSYNC ||
				ctrl_reg.mode == timer_pkg::MODE_COMPL) && i != 0) ||
				(ctrl_reg.mode == timer_pkg::MODE_PWM && outinit_reg[8+i] &&
				(i % timer_pkg::PINS_PER_CH) != 0);
			cfg  = io_ctrl_reg[i/timer_pkg::PINS_PER_CH][(i%timer_pkg::PINS_PER_CH)*
				timer_pkg::IO_FIELD_W +: timer_pkg::IO_FIELD_W];
			rise = pin_in[i] && !pin_prev_reg[i];
			fall = !pin_in[i] && pin_prev_reg[i];
			hit  = (cfg[1:0] == timer_pkg::EDGE_RISE && rise) ||
				(cfg[1:0] == timer_pkg::EDGE_FALL && fall) ||
				(cfg[1:0] == timer_pkg::EDGE_BOTH && (rise || fall));
			capture[i] = !taken && cfg[timer_pkg::CAP_EN_BIT] && hit;
		end
	end

	// Clearing sources, synchronous clearing and the up/down turnaround.
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			own_clear[c] = (clr_src_reg[c] == timer_pkg::CLR_A &&
				(match[c*4] || capture[c*4])) ||
				(clr_src_reg[c] == timer_pkg::CLR_B &&
				(match[c*4+1] || capture[c*4+1]));
		end
		if (ctrl_reg.mode == timer_pkg::MODE_RSYNC) begin
			own_clear[0] = match[0];
		end
		if (ctrl_reg.mode == timer_pkg::MODE_COMPL) begin
			own_clear = 2'b00;
		end
		sync_clear[0] = ctrl_reg.sync && clr_src_reg[0] == timer_pkg::CLR_SYNC && own_clear[1];
		sync_clear[1] = ctrl_reg.sync && clr_src_reg[1] == timer_pkg::CLR_SYNC && own_clear[0];
		turn_down = ctrl_reg.mode == timer_pkg::MODE_COMPL && !dir_down_reg && match[0];
		turn_up   = ctrl_reg.mode == timer_pkg::MODE_COMPL && dir_down_reg && tick[1] &&
			cnt_reg[1] == '0;
		dir_eff   = turn_down ? 1'b1 : (turn_up ? 1'b0 : dir_down_reg);
		dir_down_next = (ctrl_reg.mode == timer_pkg::MODE_COMPL) ? dir_eff : 1'b0;
	end

	// Write decode; a write happens once both address and data are held.
	always_comb begin
		waddr    = {aw_addr_reg[7:2], 2'b00};
		wr_go    = aw_full_reg && w_full_reg && !s_axi_bvalid;
		wr_cnt   = {wr_go && waddr == timer_pkg::OFF_CNT1, wr_go && waddr == timer_pkg::OFF_CNT0};
		cnt_wval = CW'(merge_bytes(pad(cnt_reg[wr_cnt[1]]), w_data_reg, w_strb_reg));
		wr_hit   = waddr <= timer_pkg::OFF_CNT1 || (waddr >= timer_pkg::OFF_GR_BASE &&
			waddr < timer_pkg::OFF_GR_BASE + 8'h20);
		for (int i = 0; i < 8; i++) begin
			wr_gr[i] = wr_go && waddr == timer_pkg::OFF_GR_BASE + 8'(4 * i);
		end
	end

	// Counters: a software preset wins over counting for that cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg[0] <= timer_pkg::CNT_RST[CW-1:0];
			cnt_reg[1] <= timer_pkg::CNT_RST[CW-1:0];
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (wr_cnt[k] || (ctrl_reg.sync && wr_cnt[1-k])) begin
					cnt_reg[k] <= cnt_wval;
				end else if (tick[k]) begin
					if (ctrl_reg.mode == timer_pkg::MODE_COMPL) begin
						cnt_reg[k] <= dir_eff ? cnt_reg[k] - CW'(1) : cnt_reg[k] + CW'(1);
					end else if (own_clear[k] || sync_clear[k]) begin
						cnt_reg[k] <= '0;
					end else begin
						cnt_reg[k] <= cnt_reg[k] + CW'(1);
					end
				end
			end
		end
	end

	// General registers; a capture in the same cycle as a write keeps the capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 8; i++) begin
				gr_reg[i] <= timer_pkg::GR_RST[CW-1:0];
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (capture[i]) begin
					gr_reg[i] <= cnt_reg[i/timer_pkg::PINS_PER_CH];
				end else if (wr_gr[i]) begin
					gr_reg[i] <= CW'(merge_bytes(pad(gr_reg[i]), w_data_reg, w_strb_reg));
				end
			end
		end
	end

	// Configuration registers written by software.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg       <= timer_pkg::CTRL_RST;
			clr_src_reg[0] <= timer_pkg::CLR_NONE;
			clr_src_reg[1] <= timer_pkg::CLR_NONE;
			io_ctrl_reg[0] <= timer_pkg::IO_RST;
			io_ctrl_reg[1] <= timer_pkg::IO_RST;
			outinit_reg    <= timer_pkg::OUTINIT_RST;
			pol_reg        <= timer_pkg::POL_RST;
		end else if (wr_go) begin
			case (waddr)
				timer_pkg::OFF_CTRL: begin
					ctrl_reg <= timer_pkg::ctrl_t'(7'(merge_bytes(32'(ctrl_reg), w_data_reg,
						w_strb_reg)));
				end
				timer_pkg::OFF_CLR0: begin
					clr_src_reg[0] <= timer_pkg::clr_src_t'(w_strb_reg[0] ? w_data_reg[1:0] :
						clr_src_reg[0]);
				end
				timer_pkg::OFF_CLR1: begin
					clr_src_reg[1] <= timer_pkg::clr_src_t'(w_strb_reg[0] ? w_data_reg[1:0] :
						clr_src_reg[1]);
				end
				timer_pkg::OFF_IO0: begin
					io_ctrl_reg[0] <= 16'(merge_bytes(32'(io_ctrl_reg[0]), w_data_reg, w_strb_reg));
				end
				timer_pkg::OFF_IO1: begin
					io_ctrl_reg[1] <= 16'(merge_bytes(32'(io_ctrl_reg[1]), w_data_reg, w_strb_reg));
				end
				timer_pkg::OFF_OUTINIT: begin
					outinit_reg <= 16'(merge_bytes(32'(outinit_reg), w_data_reg, w_strb_reg));
				end
				timer_pkg::OFF_POL: begin
					pol_reg <= w_strb_reg[0] ? w_data_reg[7:0] : pol_reg;
				end
				default: begin
				end
			endcase
		end
	end

	// Next pin levels for each mode; timer mode leaves the pins undriven.
	always_comb begin
		logic [CW-1:0] cp;
		logic          pn;
		logic          pc;
		cp           = '0;
		pn           = 1'b0;
		pc           = 1'b0;
		pin_out_next = pin_out;
		pin_oe_next  = '0;
		phase_next   = phase_reg;
		case (ctrl_reg.mode)
			timer_pkg::MODE_PWM: begin
				for (int i = 0; i < timer_pkg::NUM_PINS; i++) begin
					if ((i % timer_pkg::PINS_PER_CH) != 0 && outinit_reg[8+i]) begin
						pin_oe_next[i] = 1'b1;
						if (!tick[i/timer_pkg::PINS_PER_CH]) begin
							pin_out_next[i] = ~(outinit_reg[i] ^ pol_reg[i]);
						end else if (match[i]) begin
							pin_out_next[i] = pol_reg[i];
						end else if (match[(i/timer_pkg::PINS_PER_CH)*timer_pkg::PINS_PER_CH]) begin
							pin_out_next[i] = ~pol_reg[i];
						end
					end
				end
			end
			timer_pkg::MODE_RSYNC: begin
				pin_oe_next = timer_pkg::TAKEN_OE;
				if (match[0]) begin
					phase_next = 3'b111;
					pin_out_next[timer_pkg::TOGGLE_PIN] = ~pin_out[timer_pkg::TOGGLE_PIN];
				end else begin
					for (int k = 0; k < 3; k++) begin
						if (match[timer_pkg::PHASE_CP_REG[k]]) begin
							phase_next[k] = 1'b0;
						end
					end
				end
				for (int k = 0; k < 3; k++) begin
					pin_out_next[timer_pkg::PHASE_NORM_PIN[k]] = level(phase_next[k],
						ctrl_reg.normal_phase_level_select);
					pin_out_next[timer_pkg::PHASE_CNTR_PIN[k]] = level(~phase_next[k],
						ctrl_reg.counter_phase_level_select);
				end
			end
			timer_pkg::MODE_COMPL: begin
				pin_oe_next = timer_pkg::TAKEN_OE;
				if (turn_down) begin
					pin_out_next[timer_pkg::TOGGLE_PIN] = ~pin_out[timer_pkg::TOGGLE_PIN];
				end
				// The counter-phase looks at the leading counter and the normal phase at the
				// lagging one, so the gap between the two counts keeps the pair apart.
				for (int k = 0; k < 3; k++) begin
					cp = gr_reg[timer_pkg::PHASE_CP_REG[k]];
					pn = cnt_reg[1] > cp;
					pc = cnt_reg[0] < cp;
					pin_out_next[timer_pkg::PHASE_NORM_PIN[k]] = level(pn,
						ctrl_reg.normal_phase_level_select);
					pin_out_next[timer_pkg::PHASE_CNTR_PIN[k]] = level(pc,
						ctrl_reg.counter_phase_level_select);
				end
			end
			default: begin
			end
		endcase
	end

	// Pin state, edge history, phase and count direction.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out      <= '0;
			pin_oe       <= '0;
			pin_prev_reg <= '0;
			phase_reg    <= '0;
			dir_down_reg <= 1'b0;
		end else begin
			pin_out      <= pin_out_next;
			pin_oe       <= pin_oe_next;
			pin_prev_reg <= pin_in;
			phase_reg    <= phase_next;
			dir_down_reg <= dir_down_next;
		end
	end

	// Write channels; address and data are taken in either order, held until the response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= timer_pkg::RESP_OKAY;
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg   <= s_axi_awaddr;
				aw_full_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				w_full_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read decode; the status word shows live pin and direction state.
	always_comb begin
		logic [7:0] ra;
		ra      = {s_axi_araddr[7:2], 2'b00};
		rd_word = '0;
		rd_ok   = 1'b1;
		case (ra)
			timer_pkg::OFF_CTRL:    rd_word = 32'(ctrl_reg);
			timer_pkg::OFF_CLR0:    rd_word = 32'(clr_src_reg[0]);
			timer_pkg::OFF_CLR1:    rd_word = 32'(clr_src_reg[1]);
			timer_pkg::OFF_IO0:     rd_word = 32'(io_ctrl_reg[0]);
			timer_pkg::OFF_IO1:     rd_word = 32'(io_ctrl_reg[1]);
			timer_pkg::OFF_OUTINIT: rd_word = 32'(outinit_reg);
			timer_pkg::OFF_POL:     rd_word = 32'(pol_reg);
			timer_pkg::OFF_STATUS:  rd_word = {15'h0000, dir_down_reg, pin_prev_reg, pin_out};
			timer_pkg::OFF_CNT0:    rd_word = pad(cnt_reg[0]);
			timer_pkg::OFF_CNT1:    rd_word = pad(cnt_reg[1]);
			default: begin
				rd_ok = 1'b0;
				for (int i = 0; i < 8; i++) begin
					if (ra == timer_pkg::OFF_GR_BASE + 8'(4 * i)) begin
						rd_word = pad(gr_reg[i]);
						rd_ok   = 1'b1;
					end
				end
			end
		endcase
	end

	// Read channel: one answer per address, data held until taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= timer_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

//--- tb/pin_partner.sv
// Outside world at the capture and compare pins of the timer.
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
	input  wire logic       aclk,
	input  wire logic [7:0] want,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output logic [7:0]      pin_in
);
	logic [7:0] level_reg = 8'h00;

	// The source moves only just after a clock edge, so an edge never lands on the sampling edge.
	always_ff @(posedge aclk) begin
		level_reg <= want;
	end

	// A pin the block drives reads back the block's level; the others read the source.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & level_reg);
endmodule

`default_nettype wire

//--- tb/dual_channel_capture_pwm_timer_assertions.sv
// Concurrent checks on the timer's bus handshakes and pin ownership.
`timescale 1ns/1ps
`default_nettype none

module timer_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe
);
	logic [1:0] mode_reg;
	logic [1:0] lvl_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Shadow of mode and level fields; a write whose halves are taken apart would be missed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= 2'h0;
			lvl_reg  <= 2'h0;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
				&& s_axi_awaddr == timer_pkg::OFF_CTRL) begin
			mode_reg <= s_axi_wdata[4:3];
			lvl_reg  <= s_axi_wdata[6:5];
		end
	end

	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	pins_taken_a: assert property (mode_reg[1] [*4] |-> pin_oe == timer_pkg::TAKEN_OE)
		else $error("pin ownership wrong in three-phase mode");
	phase_pairs_a: assert property ((mode_reg[1] && lvl_reg == 2'h3) [*4]
		|-> !(|({pin_out[5:4], pin_out[1]} & {pin_out[7:6], pin_out[3]})))
		else $error("normal and counter phase active together");
endmodule

bind dual_channel_capture_pwm_timer timer_checker checker_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pin_out(pin_out), .pin_oe(pin_oe)
);

`default_nettype wire

//--- tb/dual_channel_capture_pwm_timer_tb.sv
// Self-checking bench for the dual-channel capture and PWM timer.
`timescale 1ns/1ps
`default_nettype none

module dual_channel_capture_pwm_timer_tb;
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [7:0]  want    = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, rdat;
	logic [7:0]  pin_in, pin_out, pin_oe;
	int          err_total = 0;
	int          checks    = 0;
	int          cyc       = 0;
	int          rp [7]    = '{1, 3, 4, 6, 5, 7, 2};
	int          re [7]    = '{40, 60, 60, 40, 80, 20, 50};

	dual_channel_capture_pwm_timer DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
	);

	pin_partner ext_pins (
		.aclk(aclk), .want(want), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
	);

	always #10 aclk = ~aclk;

	// A hang anywhere ends the run as a failure instead of stalling the regression.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Ready for the response is raised only once it is offered, so a stalled master is exercised.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er = timer_pkg::RESP_OKAY);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er = timer_pkg::RESP_OKAY);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		rdat = rdata;
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic rst();
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic grs(input logic [31:0] a0, b0, a1, b1);
		wr(timer_pkg::OFF_GR_BASE, a0);
		wr(timer_pkg::OFF_GR_BASE + 8'h04, b0);
		wr(timer_pkg::OFF_GR_BASE + 8'h10, a1);
		wr(timer_pkg::OFF_GR_BASE + 8'h14, b1);
	endtask

	// Counter is stopped, so the captured value is the preset and never a timing guess.
	task automatic cap(input logic [3:0] io, input logic [15:0] pre, input logic lvl,
			input logic [15:0] exp);
		wr(timer_pkg::OFF_IO0, {28'h0, io});
		wr(timer_pkg::OFF_CNT0, {16'h0, pre});
		want <= {7'h0, lvl};
		repeat (4) @(posedge aclk);
		rd(timer_pkg::OFF_GR_BASE);
		chk(rdat, {16'h0, exp});
	endtask

	// High cycles in a window of 100, after settling; periods here divide 100 exactly.
	task automatic duty(input int p, input int e);
		int h;
		h = 0;
		repeat (20) @(posedge aclk);
		repeat (100) begin
			@(posedge aclk);
			if (pin_out[p] === 1'b1) h++;
		end
		chk(32'(h), 32'(e));
	endtask

	task automatic give_verdict();
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		rst();
		// Reset contents and an address nothing decodes.
		rd(timer_pkg::OFF_CTRL);
		chk(rdat, 32'h0);
		rd(timer_pkg::OFF_GR_BASE);
		chk(rdat, 32'h0000FFFF);
		rd(8'hFC, timer_pkg::RESP_SLVERR);
		chk(rdat, 32'h0);
		wr(8'hFC, 32'h1, timer_pkg::RESP_SLVERR);
		// Each edge selection, with edges of the wrong kind that must leave the register alone.
		cap(4'h5, 16'h1234, 1'b1, 16'h1234);
		cap(4'h5, 16'h2222, 1'b0, 16'h1234);
		cap(4'h6, 16'h3333, 1'b1, 16'h1234);
		cap(4'h6, 16'h4444, 1'b0, 16'h4444);
		cap(4'h7, 16'h5555, 1'b1, 16'h5555);
		cap(4'h7, 16'h6666, 1'b0, 16'h6666);
		// A capture on the second pin clears a count that had grown well past the bound.
		wr(timer_pkg::OFF_IO0, 32'h50);
		wr(timer_pkg::OFF_CLR0, 32'h2);
		wr(timer_pkg::OFF_CTRL, 32'h1);
		repeat (300) @(posedge aclk);
		want <= 8'h02;
		repeat (4) @(posedge aclk);
		wr(timer_pkg::OFF_CTRL, 32'h0);
		rd(timer_pkg::OFF_CNT0);
		chk({31'h0, rdat < 32'h20}, 32'h1);
		// Synchronised channels in PWM mode, stopped first.
		rst();
		wr(timer_pkg::OFF_CTRL, 32'h0C);
		wr(timer_pkg::OFF_CNT0, 32'h0ABC);
		rd(timer_pkg::OFF_CNT1);
		chk(rdat, 32'h0ABC);
		for (int i = 0; i < 4; i++) begin
			wr(timer_pkg::OFF_OUTINIT, 32'h2200 | (32'(i[0]) << 1));
			wr(timer_pkg::OFF_POL, 32'(i[1]) << 1);
			repeat (3) @(posedge aclk);
			chk({31'h0, pin_out[1]}, {31'h0, i[0] ~^ i[1]});
		end
		wr(timer_pkg::OFF_OUTINIT, 32'h2200);
		wr(timer_pkg::OFF_POL, 32'h0);
		grs(32'h9, 32'h3, 32'h9, 32'h3);
		wr(timer_pkg::OFF_CLR0, 32'h1);
		wr(timer_pkg::OFF_CLR1, 32'h3);
		wr(timer_pkg::OFF_CNT0, 32'h0);
		wr(timer_pkg::OFF_CTRL, 32'h0F);
		duty(1, 40);
		duty(5, 40);
		wr(timer_pkg::OFF_GR_BASE + 8'h04, 32'hFFFF);
		duty(1, 100);
		wr(timer_pkg::OFF_GR_BASE + 8'h04, 32'h9);
		duty(1, 0);
		wr(timer_pkg::OFF_POL, 32'h2);
		wr(timer_pkg::OFF_GR_BASE + 8'h04, 32'h3);
		duty(1, 60);
		// Reset-synchronous mode with channel 1's own counter left stopped.
		rst();
		grs(32'h9, 32'h3, 32'h5, 32'h7);
		wr(timer_pkg::OFF_CTRL, 32'h71);
		for (int i = 0; i < 7; i++) duty(rp[i], re[i]);
		chk({24'h0, pin_oe}, {24'h0, timer_pkg::TAKEN_OE});
		// Complementary mode; overlap is watched by the checker throughout.
		// A top of 27 gives a 50-cycle up/down period, so each window holds two whole periods.
		rst();
		grs(32'h1B, 32'h8, 32'hA, 32'hC);
		wr(timer_pkg::OFF_CNT0, 32'h2);
		wr(timer_pkg::OFF_CTRL, 32'h7B);
		rd(timer_pkg::OFF_CTRL);
		chk(rdat, 32'h7B);
		repeat (300) @(posedge aclk);
		chk({24'h0, pin_oe}, {24'h0, timer_pkg::TAKEN_OE});
		duty(1, 66);
		duty(3, 22);
		duty(2, 50);
		give_verdict();
	end
endmodule

`default_nettype wire
